// ### hdl/mac_memwait_serial_antenna_cfg.v
`timescale 1ns/1ps
`default_nettype none

`include "memwait_defs.vh"

// How it works
// RULE1: flash wait code 11/10/01/00 gives 3/2/1/0 wait states; reset 11.
// RULE2: sram wait code in bits 5:4, same encoding, reset 11.
// RULE3: every wait state stretches the memory access by two input clocks.
// RULE4: polarity 0 gives positive serial clock pulse, 1 gives negative.
// RULE5: software sets polarity 1 before talking to the baseband chip.
// RULE6: software clears polarity 0 before synthesizer transfers, per routine.
// RULE7: software programs the serial control register to 40h.
// RULE8: bytes written to the fast serial register shift out on data/clock.
// RULE9: two slower serial modes exist, chosen by serial control bits.
// RULE10: override 0 lets the antenna state machine drive both select pins.
// RULE11: override 1 disables internal antenna selection logic.
// RULE12: override 1 drives pins from antenna drive bit and user pin bit.
// RULE13: software keeps override at 1 in this application.
// RULE14: user pin bit 1 sets the antenna select pin, initially 1.
// RULE15: flash and sram regions each use their own wait count.
// RULE16: a write starts eight bits msb first, one clock pulse per bit.
module mac_memwait_serial_antenna_cfg (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        memStart,
    input  wire        memIsFlash,
    input  wire        memWrite,
    output wire        memBusy,
    output reg         memDone,
    output reg         flashCe_n,
    output reg         sramCe_n,
    output reg         memOe_n,
    output reg         memWe_n,
    output wire        serialClockOut,
    output wire        serialDataOut,
    input  wire        antennaSwapReq,
    output reg         antennaSelectOut,
    output reg         antennaSelectOutB
);

    // ------------------------------------------------------------------
    // local state codes
    // ------------------------------------------------------------------
    localparam [1:0] MEM_IDLE   = 2'b00;
    localparam [1:0] MEM_ACCESS = 2'b01;
    localparam [1:0] MEM_DONE   = 2'b10;
    localparam       ANT_A      = 1'b0;
    localparam       ANT_B      = 1'b1;
    localparam [31:0] BASE_CYC  = `BASE_ACCESS_CYC;
    localparam [31:0] WAIT_CYC  = `WAIT_STATE_CYC;

    // ------------------------------------------------------------------
    // registers and internal signals
    // ------------------------------------------------------------------
    reg  [7:0]  flashWaitConfig_r;
    reg  [7:0]  sramWaitConfig_r;
    reg  [7:0]  serialPortControl_r;
    reg  [7:0]  fastSerialData_r;
    reg  [7:0]  antennaPinControl_r;
    reg  [7:0]  userPinControl_r;
    reg  [31:0] prdata_r;
    reg  [1:0]  memState_r;
    reg  [1:0]  memState_nxt;
    reg  [3:0]  memCnt_r;
    reg  [3:0]  memCnt_nxt;
    reg         memFlash_r;
    reg         memWr_r;
    reg         antState_r;
    reg         rdHit;
    reg  [7:0]  rdByte;
    wire        apbWrite;
    wire        shifterBusy;
    wire        shifterClk;
    wire        shifterData;
    wire        serialStart;
    wire [1:0]  serialMode;
    wire [1:0]  flashWaitCount;
    wire [1:0]  sramWaitCount;
    wire        serialClockPolarity;
    wire        antennaPinOverride;
    wire        antennaSelectDriveValue;
    wire        antennaSelectUserValue;

    // ------------------------------------------------------------------
    // field extraction
    // ------------------------------------------------------------------
    assign flashWaitCount          = flashWaitConfig_r[`FLASH_WAIT_LSB +: 2];
    assign sramWaitCount           = sramWaitConfig_r[`SRAM_WAIT_LSB +: 2];
    assign serialMode              = serialPortControl_r[`SER_MODE_LSB +: 2];
    assign serialClockPolarity     = serialPortControl_r[`SER_POLARITY_BIT];
    assign antennaPinOverride      = antennaPinControl_r[`ANT_OVERRIDE_BIT];
    assign antennaSelectDriveValue = antennaPinControl_r[`ANT_DRIVE_BIT];
    assign antennaSelectUserValue  = userPinControl_r[`USER_ANT_BIT];

    // total access length: base plus two clocks per wait state
    function [3:0] accessCycles;
        input [1:0] waitCode;
        begin
            accessCycles = BASE_CYC[3:0] + {2'b00, waitCode} * WAIT_CYC[3:0]; // see RULE3
        end
    endfunction

    // ------------------------------------------------------------------
    // apb slave: zero-wait, read data captured in the setup cycle
    // ------------------------------------------------------------------
    assign apbWrite = psel && penable && pwrite && rdHit;
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !rdHit;   // unmapped address answers error
    assign prdata   = prdata_r;

    // address decode; the busy flag lets software poll before next byte
    always @* begin
        rdHit  = 1'b1;
        rdByte = 8'h00;
        if (paddr == `REG_FLASH_WAIT) begin
            rdByte = flashWaitConfig_r;
        end else if (paddr == `REG_SRAM_WAIT) begin
            rdByte = sramWaitConfig_r;
        end else if (paddr == `REG_SERIAL_CTRL) begin
            rdByte = {shifterBusy, serialPortControl_r[6:0]};
        end else if (paddr == `REG_FAST_SERIAL) begin
            rdByte = fastSerialData_r;
        end else if (paddr == `REG_ANTENNA_CTRL) begin
            rdByte = antennaPinControl_r;
        end else if (paddr == `REG_USER_PIN) begin
            rdByte = userPinControl_r;
        end else begin
            rdHit = 1'b0;
        end
    end

    // read data register, loaded in the setup phase
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_r <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata_r <= {24'h000000, rdByte};
        end
    end

    // configuration registers, written at the access edge only
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flashWaitConfig_r   <= `RST_FLASH_WAIT;     // see RULE1
            sramWaitConfig_r    <= `RST_SRAM_WAIT;      // see RULE2
            serialPortControl_r <= `RST_SERIAL_CTRL;
            fastSerialData_r    <= `RST_FAST_SERIAL;
            antennaPinControl_r <= `RST_ANTENNA_CTRL;
            userPinControl_r    <= `RST_USER_PIN;       // see RULE14
        end else if (apbWrite) begin
            if (paddr == `REG_FLASH_WAIT) begin
                flashWaitConfig_r <= pwdata[7:0];
            end else if (paddr == `REG_SRAM_WAIT) begin
                sramWaitConfig_r <= pwdata[7:0];
            end else if (paddr == `REG_SERIAL_CTRL) begin
                serialPortControl_r <= {1'b0, pwdata[6:0]}; // top bit is status
            end else if (paddr == `REG_FAST_SERIAL) begin
                fastSerialData_r <= pwdata[7:0];
            end else if (paddr == `REG_ANTENNA_CTRL) begin
                antennaPinControl_r <= pwdata[7:0];
            end else if (paddr == `REG_USER_PIN) begin
                userPinControl_r <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // serial link
    // ------------------------------------------------------------------
    // a byte written in fast or slow mode starts a shift; writes while
    // busy only update the register, so software must poll busy first
    assign serialStart = apbWrite && (paddr == `REG_FAST_SERIAL)
                         && (serialMode != `SER_MODE_MANUAL);   // see RULE8

    serial_shifter shifter (
        .clk            (clk),
        .rst_n          (rst_n),
        .start          (serialStart),
        .txByte         (pwdata[7:0]),
        .polarity       (serialClockPolarity),
        .slowMode       (serialMode == `SER_MODE_SLOW),
        .busy           (shifterBusy),
        .serialClockOut (shifterClk),
        .serialDataOut  (shifterData)
    );

    // manual mode hands both pins to register bits (slowest method)
    assign serialClockOut = (serialMode == `SER_MODE_MANUAL)
                            ? serialPortControl_r[`SER_MAN_CLK_BIT] : shifterClk;  // see RULE9
    assign serialDataOut  = (serialMode == `SER_MODE_MANUAL)
                            ? serialPortControl_r[`SER_MAN_DATA_BIT] : shifterData; // see RULE9

    // ------------------------------------------------------------------
    // asynchronous memory strobe generator
    // ------------------------------------------------------------------
    assign memBusy = (memState_r != MEM_IDLE);

    // next-state logic; region picks its own wait count
    always @* begin
        memState_nxt = memState_r;
        memCnt_nxt   = memCnt_r;
        case (memState_r)
            MEM_IDLE: begin
                if (memStart) begin
                    memState_nxt = MEM_ACCESS;
                    memCnt_nxt   = memIsFlash ? accessCycles(flashWaitCount) - 4'h1
                                              : accessCycles(sramWaitCount) - 4'h1; // see RULE15
                end
            end
            MEM_ACCESS: begin
                if (memCnt_r == 4'h0) begin
                    memState_nxt = MEM_DONE;
                end else begin
                    memCnt_nxt = memCnt_r - 4'h1;
                end
            end
            MEM_DONE: begin
                memState_nxt = MEM_IDLE;
            end
            default: begin
                memState_nxt = MEM_IDLE;
            end
        endcase
    end

    // strobes are registered so the pins never glitch
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            memState_r <= MEM_IDLE;
            memCnt_r   <= 4'h0;
            memFlash_r <= 1'b0;
            memWr_r    <= 1'b0;
            memDone    <= 1'b0;
            flashCe_n  <= 1'b1;
            sramCe_n   <= 1'b1;
            memOe_n    <= 1'b1;
            memWe_n    <= 1'b1;
        end else begin
            memState_r <= memState_nxt;
            memCnt_r   <= memCnt_nxt;
            memDone    <= (memState_r == MEM_ACCESS) && (memCnt_r == 4'h0);
            if (memState_r == MEM_IDLE && memStart) begin
                memFlash_r <= memIsFlash;
                memWr_r    <= memWrite;
                flashCe_n  <= !memIsFlash;
                sramCe_n   <= memIsFlash;
                memOe_n    <= memWrite;
                memWe_n    <= !memWrite;
            end else if (memState_nxt != MEM_ACCESS) begin
                flashCe_n <= 1'b1;           // see RULE1
                sramCe_n  <= 1'b1;           // see RULE2
                memOe_n   <= 1'b1;
                memWe_n   <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // antenna selection
    // ------------------------------------------------------------------
    // internal state machine swaps antennas on request; it is frozen
    // while overridden so it cannot fight firmware-driven pins
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            antState_r <= ANT_A;
        end else if (!antennaPinOverride && antennaSwapReq) begin   // see RULE11
            case (antState_r)
                ANT_A:   antState_r <= ANT_B;
                default: antState_r <= ANT_A;
            endcase
        end
    end

    // pin drivers, registered
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            antennaSelectOut  <= 1'b0;
            antennaSelectOutB <= 1'b1;
        end else if (antennaPinOverride) begin
            antennaSelectOut  <= antennaSelectDriveValue;   // see RULE12
            antennaSelectOutB <= antennaSelectUserValue;    // see RULE12 RULE14
        end else begin
            antennaSelectOut  <= (antState_r == ANT_B);     // see RULE10
            antennaSelectOutB <= (antState_r == ANT_A);     // see RULE10
        end
    end

endmodule // mac_memwait_serial_antenna_cfg

`default_nettype wire

// ### hdl/serial_shifter.v
`timescale 1ns/1ps
`default_nettype none

`include "memwait_defs.vh"

module serial_shifter (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       start,
    input  wire [7:0] txByte,
    input  wire       polarity,
    input  wire       slowMode,
    output wire       busy,
    output reg        serialClockOut,
    output wire       serialDataOut
);

    reg [7:0] shift_r;
    reg [2:0] bitCnt_r;
    reg [2:0] divCnt_r;
    reg       phase_r;
    reg       busy_r;
    wire [2:0] halfLen;

    // half-period reload values, cut to the counter width on purpose
    localparam [31:0] FAST_HALF_M1 = `FAST_HALF_CYC - 1;
    localparam [31:0] SLOW_HALF_M1 = `SLOW_HALF_CYC - 1;

    // ------------------------------------------------------------------
    // half-period length, chosen per transfer mode
    // ------------------------------------------------------------------
    assign halfLen = slowMode ? SLOW_HALF_M1[2:0] : FAST_HALF_M1[2:0];
    assign busy          = busy_r;
    assign serialDataOut = shift_r[7];

    // msb first, one pulse per bit; data settles during the idle half
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_r        <= 8'h00;
            bitCnt_r       <= 3'h0;
            divCnt_r       <= 3'h0;
            phase_r        <= 1'b0;
            busy_r         <= 1'b0;
            serialClockOut <= 1'b0;
        end else if (!busy_r) begin
            serialClockOut <= polarity;               // idle level, see RULE4
            if (start) begin                          // see RULE16
                shift_r  <= txByte;
                bitCnt_r <= 3'h7;
                divCnt_r <= halfLen;
                phase_r  <= 1'b0;
                busy_r   <= 1'b1;
            end
        end else if (divCnt_r != 3'h0) begin
            divCnt_r <= divCnt_r - 3'h1;
        end else begin
            divCnt_r <= halfLen;
            if (!phase_r) begin
                serialClockOut <= ~polarity;          // active edge, see RULE4
                phase_r        <= 1'b1;
            end else begin
                serialClockOut <= polarity;
                phase_r        <= 1'b0;
                shift_r        <= {shift_r[6:0], 1'b0};
                if (bitCnt_r == 3'h0) begin
                    busy_r <= 1'b0;
                end else begin
                    bitCnt_r <= bitCnt_r - 3'h1;
                end
            end
        end
    end

endmodule // serial_shifter

`default_nettype wire

// ### shared/memwait_defs.vh
`ifndef MEMWAIT_DEFS_VH
`define MEMWAIT_DEFS_VH

// ----------------------------------------------------------------------
// register byte addresses (one aligned 32-bit word each)
// ----------------------------------------------------------------------
`define REG_FLASH_WAIT      8'h00
`define REG_SRAM_WAIT       8'h04
`define REG_SERIAL_CTRL     8'h08
`define REG_FAST_SERIAL     8'h0C
`define REG_ANTENNA_CTRL    8'h10
`define REG_USER_PIN        8'h14

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define FLASH_WAIT_LSB      0
`define SRAM_WAIT_LSB       4
`define SER_MODE_LSB        0
`define SER_POLARITY_BIT    2
`define SER_MAN_CLK_BIT     3
`define SER_MAN_DATA_BIT    4
`define SER_BUSY_BIT        7
`define ANT_OVERRIDE_BIT    3
`define ANT_DRIVE_BIT       4
`define USER_ANT_BIT        1

// serial link modes held in the mode field
`define SER_MODE_FAST       2'h0
`define SER_MODE_SLOW       2'h1
`define SER_MODE_MANUAL     2'h2

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_FLASH_WAIT      8'h03
`define RST_SRAM_WAIT       8'h30
`define RST_SERIAL_CTRL     8'h00
`define RST_FAST_SERIAL     8'h00
`define RST_ANTENNA_CTRL    8'h00
`define RST_USER_PIN        8'h02

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS       25
`define WAIT_STATE_NS       50
`define BASE_ACCESS_NS      50
`define WAIT_STATE_CYC      ((`WAIT_STATE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BASE_ACCESS_CYC     ((`BASE_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FAST_HALF_CYC       1
`define SLOW_HALF_CYC       4

`endif

// ### sim/mac_memwait_serial_antenna_cfg_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "memwait_defs.vh"

module mac_memwait_serial_antenna_cfg_sva (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        memStart,
    input wire logic        memIsFlash,
    input wire logic        memWrite,
    input wire logic        memBusy,
    input wire logic        memDone,
    input wire logic        flashCe_n,
    input wire logic        sramCe_n,
    input wire logic        memOe_n,
    input wire logic        memWe_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // both enables high means the memory bus is idle
    wire logic       ceAll = flashCe_n & sramCe_n;
    logic      [3:0] lowCnt_r;

    // strobe length counter, odd lengths would mean a half wait state
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            lowCnt_r <= 4'h0;
        else
            lowCnt_r <= ceAll ? 4'h0 : lowCnt_r + 4'h1;
    end

    sequence s_take; memStart && !memBusy; endsequence
    sequence s_lowTwo; !ceAll [*2]; endsequence
    sequence s_finish; memDone ##1 (!memDone && !memBusy); endsequence

    property p_noBoth; !(!flashCe_n && !sramCe_n); endproperty
    property p_region; s_take |=> memBusy && flashCe_n == !$past(memIsFlash)
        && sramCe_n == $past(memIsFlash); endproperty
    property p_dir; s_take |=> memWe_n == !$past(memWrite) && memOe_n == $past(memWrite);
    endproperty
    property p_minLen; $fell(ceAll) |-> s_lowTwo; endproperty
    property p_maxLen; $fell(ceAll) |-> ##[2:8] $rose(ceAll); endproperty
    property p_even; $rose(ceAll) |-> !lowCnt_r[0] && lowCnt_r >= 4'h2; endproperty
    property p_done; $rose(ceAll) |-> s_finish; endproperty
    property p_doneCause; memDone |-> $rose(ceAll); endproperty
    property p_idle; !memBusy && !memStart |=> ceAll; endproperty
    property p_apb; psel && penable |-> pready && pslverr == !(paddr inside {`REG_FLASH_WAIT,
        `REG_SRAM_WAIT, `REG_SERIAL_CTRL, `REG_FAST_SERIAL, `REG_ANTENNA_CTRL, `REG_USER_PIN});
    endproperty

    a_noBoth: assert property (p_noBoth) else $error("both enables low");
    a_region: assert property (p_region) else $error("wrong region strobed");
    a_dir: assert property (p_dir) else $error("wrong direction strobe");
    a_minLen: assert property (p_minLen) else $error("access too short");
    a_maxLen: assert property (p_maxLen) else $error("access too long");
    a_even: assert property (p_even) else $error("odd access length");
    a_done: assert property (p_done) else $error("done pulse missing");
    a_doneCause: assert property (p_doneCause) else $error("stray done");
    a_idle: assert property (p_idle) else $error("strobe without start");
    a_apb: assert property (p_apb) else $error("bus answer wrong");
endmodule // mac_memwait_serial_antenna_cfg_sva

bind mac_memwait_serial_antenna_cfg mac_memwait_serial_antenna_cfg_sva checker_i (
    .clk, .rst_n, .psel, .penable, .paddr, .pready, .pslverr, .memStart, .memIsFlash,
    .memWrite, .memBusy, .memDone, .flashCe_n, .sramCe_n, .memOe_n, .memWe_n);
`default_nettype wire

// ### sim/mac_memwait_serial_antenna_cfg_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "memwait_defs.vh"

module mac_memwait_serial_antenna_cfg_test;
    logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pol = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdat, expVal, rnd = 32'h97C1A22E;
    logic        pready, pslverr, rerr, memBusy, memDone, resValid;
    logic        memStart = 0, memIsFlash = 0, memWrite = 0, antennaSwapReq = 0;
    logic        flashCe_n, sramCe_n, memOe_n, memWe_n;
    logic        serialClockOut, serialDataOut, antennaSelectOut, antennaSelectOutB;
    logic [7:0]  resVal;
    logic [7:0]  rstTab [6] = '{8'h03, 8'h30, 8'h00, 8'h00, 8'h00, 8'h02};
    logic [31:0] expQ [$];
    int          num_errors = 0, num_checks = 0;

    always #12.5 clk = ~clk;

    mac_memwait_serial_antenna_cfg dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .memStart, .memIsFlash, .memWrite, .memBusy,
        .memDone, .flashCe_n, .sramCe_n, .memOe_n, .memWe_n, .serialClockOut,
        .serialDataOut, .antennaSwapReq, .antennaSelectOut, .antennaSelectOutB);
    mem_radio_model partner (.clk, .rst_n, .flashCe_n, .sramCe_n, .memWe_n,
        .serialClockOut, .serialDataOut, .pol, .resValid, .resVal);

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one full setup plus access transfer, released after pready
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= {24'h0, data};
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask

    task automatic swap;
        antennaSwapReq <= 1'h1;
        @(posedge clk);
        antennaSwapReq <= 1'h0;
        repeat (3) @(posedge clk);
    endtask

    task give_verdict;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // result watcher: every partner result meets the oldest note
    always @(posedge clk) begin
        if (resValid === 1'h1) begin
            expVal = 32'hFFFFFFFF;
            if (expQ.size() > 0)
                expVal = expQ.pop_front();
            chk({24'h0, resVal}, expVal);
        end
    end

    // watchdog, generous against roughly 430 cycles of tests
    initial begin
        #200000;
        num_errors++;
        give_verdict();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            apb(1'h0, 8'(i * 4), 8'h00);
            chk(rdat, {24'h0, rstTab[i]});
        end
        apb(1'h1, 8'h18, 8'hFF);
        chk(rerr, 1'h1);
        chk({antennaSelectOut, antennaSelectOutB}, 2'h1);
        $display("test registers done");
        // every code in each region, the other region set differently
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            apb(1'h1, `REG_FLASH_WAIT, i[2] ? {6'h0, i[1:0]} : {6'h0, ~i[1:0]});
            apb(1'h1, `REG_SRAM_WAIT, i[2] ? {2'h0, ~i[1:0], 4'h0} : {2'h0, i[1:0], 4'h0});
            memIsFlash <= i[2];
            memWrite <= rnd[0];
            memStart <= 1'h1;
            expQ.push_back({i[2], rnd[0], 3'h0, i[1:0], 1'h0} + 8'h2);
            repeat (2) @(posedge clk); // second edge hits a busy bus and is ignored
            memStart <= 1'h0;
            repeat (2 * i[1:0] + 4) @(posedge clk);
        end
        $display("test memory done");
        swap();
        chk({antennaSelectOut, antennaSelectOutB}, 2'h2);
        for (int i = 0; i < 4; i++) begin
            apb(1'h1, `REG_ANTENNA_CTRL, {3'h0, i[0], 4'h8});
            apb(1'h1, `REG_USER_PIN, {6'h0, i[1], 1'h0});
            swap(); // must have no effect while firmware owns the pins
            chk({antennaSelectOut, antennaSelectOutB}, {i[0], i[1]});
        end
        // odd swap count: a state machine left running would now sit on antenna a
        swap();
        apb(1'h1, `REG_ANTENNA_CTRL, 8'h00);
        @(posedge clk);
        chk({antennaSelectOut, antennaSelectOutB}, 2'h2);
        $display("test antenna done");
        // fast and slow mode in both polarities, second byte lands while busy
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            pol <= i[0];
            apb(1'h1, `REG_SERIAL_CTRL, {5'h8, i[0], 1'h0, i[1]});
            apb(1'h1, `REG_FAST_SERIAL, rnd[7:0]);
            expQ.push_back(rnd[7:0]);
            apb(1'h1, `REG_FAST_SERIAL, ~rnd[7:0]);
            repeat (i[1] ? 70 : 20) @(posedge clk);
        end
        apb(1'h1, `REG_SERIAL_CTRL, 8'h1A);
        repeat (3) @(posedge clk);
        chk({serialClockOut, serialDataOut}, 2'h3);
        apb(1'h1, `REG_SERIAL_CTRL, 8'h02);
        repeat (3) @(posedge clk);
        chk({serialClockOut, serialDataOut}, 2'h0);
        chk(expQ.size(), 0);
        $display("test serial done");
        give_verdict();
    end
endmodule // mac_memwait_serial_antenna_cfg_test
`default_nettype wire

// ### sim/mem_radio_model.sv
`timescale 1ns/1ps
`default_nettype none

module mem_radio_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       flashCe_n,
    input  wire logic       sramCe_n,
    input  wire logic       memWe_n,
    input  wire logic       serialClockOut,
    input  wire logic       serialDataOut,
    input  wire logic       pol,
    output var  logic       resValid,
    output var  logic [7:0] resVal
);
    logic [5:0] lowCnt_r;
    logic       flash_r, write_r, lastClk_r;
    logic [7:0] shift_r;
    logic [2:0] bitCnt_r;

    // memory side measures strobe width, radio side shifts in bytes
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {resValid, resVal, lowCnt_r, flash_r, write_r} <= '0;
            {lastClk_r, shift_r, bitCnt_r} <= '0;
        end else begin
            resValid <= 1'h0;
            lastClk_r <= serialClockOut;
            if (!(flashCe_n & sramCe_n)) begin
                lowCnt_r <= lowCnt_r + 6'h1;
                flash_r <= !flashCe_n;
                write_r <= !memWe_n;
            end else if (lowCnt_r != 6'h0) begin
                resValid <= 1'h1;
                resVal <= {flash_r, write_r, lowCnt_r};
                lowCnt_r <= 6'h0;
            end
            // data taken as the clock leaves its idle level
            if (serialClockOut != lastClk_r && serialClockOut == !pol) begin
                shift_r <= {shift_r[6:0], serialDataOut};
                bitCnt_r <= bitCnt_r + 3'h1;
                if (bitCnt_r == 3'h7) begin
                    resValid <= 1'h1;
                    resVal <= {shift_r[6:0], serialDataOut};
                end
            end
        end
    end
endmodule // mem_radio_model
`default_nettype wire
